// ### shared/dcr_map.vh
// register offsets, field positions and reset values of the card register bank
`ifndef DCR_MAP_VH
`define DCR_MAP_VH

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define DCR_ADDR_W 10
`define DCR_OFS_W 4
`define DCR_BASE_W 6
`define DCR_BASE_DEFAULT 6'h22

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCR_OFS_TMR0 4'h0
`define DCR_OFS_TMR1 4'h1
`define DCR_OFS_TMR2 4'h2
`define DCR_OFS_TMRCTL 4'h3
`define DCR_OFS_AO_A_LO 4'h4
`define DCR_OFS_AO_A_HI 4'h5
`define DCR_OFS_AO_B_LO 4'h6
`define DCR_OFS_AO_B_HI 4'h7
`define DCR_OFS_IRQCLR 4'h8
`define DCR_OFS_GAIN 4'h9
`define DCR_OFS_CHSEL 4'ha
`define DCR_OFS_MODE 4'hb
`define DCR_OFS_TRIG 4'hc
`define DCR_OFS_DO_LO 4'hd
`define DCR_OFS_DO_HI 4'he

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define DCR_BUSY_BIT 4
`define DCR_NIB_MSB 3
`define DCR_MODE_MSB 2
`define DCR_MODE_IRQ 3'h6
`define DCR_GAIN_HALF 4'h8
`define DCR_ZERO8 8'h00
`define DCR_ZERO12 12'h000
`define DCR_ZERO4 4'h0
`define DCR_ZERO3 3'h0

`endif

// ### verilog/dcr_regbank.v
// host register bank of the multifunction acquisition card
`timescale 1ns/1ps
`include "dcr_map.vh"

module dcr_regbank (
   input wire SYS_CLK_IN, // 20 MHz bus clock
   input wire RST_B_IN, // asynchronous reset, active low
   input wire [`DCR_ADDR_W-1:0] IO_ADDR_IN, // host I/O address
   input wire IO_RD_IN, // one-cycle read strobe
   input wire IO_WR_IN, // one-cycle write strobe
   input wire [7:0] IO_WDATA_IN, // write data
   input wire [`DCR_BASE_W-1:0] BASE_SEL_IN, // base switch, address bits 9..4
   output reg [7:0] IO_RDATA_OUT, // read data, registered
   output wire IO_SEL_OUT, // address hits this card
   output wire [1:0] TMR_SEL_OUT, // timer channel/control select
   output wire TMR_RD_OUT, // timer read strobe
   output wire TMR_WR_OUT, // timer write strobe
   output wire [7:0] TMR_WDATA_OUT, // timer write data
   input wire [7:0] TMR_RDATA_IN, // timer read data
   input wire CONV_DONE_IN, // one-cycle pulse: result stored
   input wire [11:0] CONV_RESULT_IN, // converter result
   input wire DIFF_MODE_IN, // differential input strap (pin)
   input wire [15:0] DIN_IN, // digital input pins
   input wire HIGH_GAIN_IN, // strap: high-gain variant (pin)
   output reg [11:0] AO_A_OUT, // first output latch
   output reg [11:0] AO_B_OUT, // second output latch
   output reg [3:0] GAIN_CODE_OUT, // gain code
   output reg [9:0] GAIN_FACTOR_X2_OUT, // decoded gain times two
   output reg GAIN_ONE_SIDED_OUT, // one_sided_range selected
   output reg [3:0] CHAN_SEL_OUT, // effective input channel
   output reg [2:0] MODE_OUT, // conversion mode code
   output reg [15:0] DOUT_OUT, // digital output latch
   output reg CONV_START_OUT, // one-cycle conversion start
   output wire IRQ_OUT // conversion interrupt request
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // offset equality for one decoded access
   function hit;
      input [`DCR_OFS_W-1:0] ofs;
      input [`DCR_OFS_W-1:0] want;
      begin
         hit = (ofs == want);
      end
   endfunction

   // gain times two, so that the half step stays integral
   function [9:0] gain_x2;
      input [3:0] code;
      input hi;
      begin
         if (code == `DCR_GAIN_HALF) begin
            gain_x2 = 10'h001;
         end else if (hi) begin
            case (code[1:0])
               2'h0: gain_x2 = 10'h002;
               2'h1: gain_x2 = 10'h014;
               2'h2: gain_x2 = 10'h0c8;
               // twice 1000 does not fit ten bits, so the top factor saturates
               default: gain_x2 = 10'h3ff;
            endcase
         end else begin
            case (code[1:0])
               2'h0: gain_x2 = 10'h002;
               2'h1: gain_x2 = 10'h004;
               2'h2: gain_x2 = 10'h008;
               default: gain_x2 = 10'h010;
            endcase
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire [`DCR_OFS_W-1:0] ofs = IO_ADDR_IN[`DCR_OFS_W-1:0];
   wire in_block = (IO_ADDR_IN[`DCR_ADDR_W-1:`DCR_OFS_W] == BASE_SEL_IN);
   wire wr = IO_WR_IN & in_block;
   wire rd = IO_RD_IN & in_block;
   assign IO_SEL_OUT = in_block;

   // timer writes pass straight through for offsets 0..3, reads only for 0..2
   wire tmr_hit = (ofs <= `DCR_OFS_TMRCTL);
   assign TMR_SEL_OUT = ofs[1:0];
   assign TMR_WR_OUT = wr & tmr_hit;
   assign TMR_RD_OUT = rd & tmr_hit & ~hit(ofs, `DCR_OFS_TMRCTL);
   assign TMR_WDATA_OUT = IO_WDATA_IN;

   // ----------------------------------------------------------------
   // pin synchronisers, three stages, accept when last two agree
   // ----------------------------------------------------------------
   reg [17:0] s1_q, s2_q, s3_q;
   reg [17:0] pin_q;
   wire [17:0] pin_raw = {HIGH_GAIN_IN, DIFF_MODE_IN, DIN_IN};
   always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         s1_q <= 18'h00000;
         s2_q <= 18'h00000;
         s3_q <= 18'h00000;
         pin_q <= 18'h00000;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
      end
   end
   wire [15:0] din_sync = pin_q[15:0];
   wire diff_sync = pin_q[16];
   wire hi_gain_sync = pin_q[17];

   // ----------------------------------------------------------------
   // write-side registers
   // ----------------------------------------------------------------
   reg [7:0] hold_a_q, hold_b_q;
   reg [3:0] chan_q;
   reg busy_q, done_q;
   always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         hold_a_q <= `DCR_ZERO8;
         hold_b_q <= `DCR_ZERO8;
         AO_A_OUT <= `DCR_ZERO12;
         AO_B_OUT <= `DCR_ZERO12;
         GAIN_CODE_OUT <= `DCR_ZERO4;
         chan_q <= `DCR_ZERO4;
         MODE_OUT <= `DCR_ZERO3;
         DOUT_OUT <= 16'h0000;
         CONV_START_OUT <= 1'b0;
      end else begin
         CONV_START_OUT <= wr & hit(ofs, `DCR_OFS_TRIG);
         if (wr) begin
            if (hit(ofs, `DCR_OFS_AO_A_LO)) begin
               hold_a_q <= IO_WDATA_IN;
            end else if (hit(ofs, `DCR_OFS_AO_A_HI)) begin
               // latch takes whatever low byte is held, fresh or stale
               AO_A_OUT <= {IO_WDATA_IN[`DCR_NIB_MSB:0], hold_a_q};
            end else if (hit(ofs, `DCR_OFS_AO_B_LO)) begin
               hold_b_q <= IO_WDATA_IN;
            end else if (hit(ofs, `DCR_OFS_AO_B_HI)) begin
               AO_B_OUT <= {IO_WDATA_IN[`DCR_NIB_MSB:0], hold_b_q};
            end else if (hit(ofs, `DCR_OFS_GAIN)) begin
               GAIN_CODE_OUT <= IO_WDATA_IN[`DCR_NIB_MSB:0];
            end else if (hit(ofs, `DCR_OFS_CHSEL)) begin
               chan_q <= IO_WDATA_IN[`DCR_NIB_MSB:0];
            end else if (hit(ofs, `DCR_OFS_MODE)) begin
               MODE_OUT <= IO_WDATA_IN[`DCR_MODE_MSB:0];
            end else if (hit(ofs, `DCR_OFS_DO_LO)) begin
               DOUT_OUT[7:0] <= IO_WDATA_IN;
            end else if (hit(ofs, `DCR_OFS_DO_HI)) begin
               DOUT_OUT[15:8] <= IO_WDATA_IN;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // gain and channel decode (settling wait is software's job)
   // ----------------------------------------------------------------
   always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         GAIN_FACTOR_X2_OUT <= 10'h002;
         GAIN_ONE_SIDED_OUT <= 1'b0;
         CHAN_SEL_OUT <= `DCR_ZERO4;
      end else begin
         GAIN_FACTOR_X2_OUT <= gain_x2(GAIN_CODE_OUT, hi_gain_sync);
         GAIN_ONE_SIDED_OUT <= GAIN_CODE_OUT[2];
         CHAN_SEL_OUT <= {chan_q[3] & ~diff_sync, chan_q[2:0]};
      end
   end

   // ----------------------------------------------------------------
   // pending flag and conversion-done bit
   // ----------------------------------------------------------------
   // a start arriving with a completion wins, so a new conversion reads busy
   wire irq_mode = (MODE_OUT == `DCR_MODE_IRQ);
   always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (CONV_START_OUT) begin
            busy_q <= 1'b1;
         end else if (CONV_DONE_IN) begin
            busy_q <= 1'b0;
         end
         if (CONV_DONE_IN & irq_mode) begin
            done_q <= 1'b1;
         end else if (wr & hit(ofs, `DCR_OFS_IRQCLR)) begin
            done_q <= 1'b0;
         end
      end
   end
   assign IRQ_OUT = done_q;

   // ----------------------------------------------------------------
   // read mux, registered one cycle after the strobe
   // ----------------------------------------------------------------
   reg [7:0] rd_d;
   always @* begin
      rd_d = `DCR_ZERO8;
      if (tmr_hit & ~hit(ofs, `DCR_OFS_TMRCTL)) begin
         rd_d = TMR_RDATA_IN;
      end else if (hit(ofs, `DCR_OFS_AO_A_LO)) begin
         rd_d = CONV_RESULT_IN[7:0];
      end else if (hit(ofs, `DCR_OFS_AO_A_HI)) begin
         rd_d = {3'h0, busy_q, CONV_RESULT_IN[11:8]};
      end else if (hit(ofs, `DCR_OFS_AO_B_LO)) begin
         rd_d = din_sync[7:0];
      end else if (hit(ofs, `DCR_OFS_AO_B_HI)) begin
         rd_d = din_sync[15:8];
      end
   end
   always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         IO_RDATA_OUT <= `DCR_ZERO8;
      end else if (rd) begin
         IO_RDATA_OUT <= rd_d;
      end
   end

endmodule // dcr_regbank

// ### test/dcr_regbank_props.sv
// concurrent checks on the card register bank ports
`timescale 1ns/1ps
`include "dcr_map.vh"
module dcr_regbank_props (
   input wire SYS_CLK_IN, // bus clock
   input wire RST_B_IN, // reset, active low
   input wire [`DCR_ADDR_W-1:0] IO_ADDR_IN, // host address
   input wire IO_RD_IN, // read strobe
   input wire IO_WR_IN, // write strobe
   input wire [`DCR_BASE_W-1:0] BASE_SEL_IN, // base switch
   input wire [7:0] IO_RDATA_OUT, // read data
   input wire CONV_DONE_IN, // conversion done pulse
   input wire [2:0] MODE_OUT, // mode code
   input wire [11:0] AO_A_OUT, // first output latch
   input wire CONV_START_OUT, // start pulse
   input wire IRQ_OUT // interrupt request
);
   // block decode seen from the pins
   wire hit = IO_ADDR_IN[9:4] == BASE_SEL_IN;
   wire [3:0] ofs = IO_ADDR_IN[3:0];
   wire clr_wr = IO_WR_IN && hit && ofs == 4'h8;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   property p_miss; IO_RD_IN && !hit |=> $stable(IO_RDATA_OUT); endproperty
   property p_rsv; IO_RD_IN && hit && (ofs == 4'h3 || ofs[3]) |=> IO_RDATA_OUT == 8'h00; endproperty
   property p_start; IO_WR_IN && hit && ofs == 4'hc |=> CONV_START_OUT; endproperty
   property p_start_src; CONV_START_OUT |-> $past(IO_WR_IN && hit && ofs == 4'hc); endproperty
   property p_irq_set; CONV_DONE_IN && MODE_OUT == 3'h6 |=> IRQ_OUT; endproperty
   property p_clr; clr_wr && !CONV_DONE_IN |=> !IRQ_OUT; endproperty
   property p_irq_hold; IRQ_OUT && !clr_wr |=> IRQ_OUT; endproperty
   property p_ao; !(IO_WR_IN && hit && ofs == 4'h5) |=> $stable(AO_A_OUT); endproperty
   a_miss: assert property (p_miss) else $error("read data moved on a miss");
   a_rsv: assert property (p_rsv) else $error("reserved read not zero");
   a_start: assert property (p_start) else $error("no start pulse");
   a_start_src: assert property (p_start_src) else $error("stray start pulse");
   a_irq_set: assert property (p_irq_set) else $error("irq not raised");
   a_clr: assert property (p_clr) else $error("irq not cleared");
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
   a_ao: assert property (p_ao) else $error("latch moved without high write");
   c_irq: cover property (CONV_DONE_IN && MODE_OUT == 3'h6);
   c_start: cover property (CONV_START_OUT);
   c_rsv: cover property (IO_RD_IN && hit && ofs[3]);
endmodule // dcr_regbank_props
bind dcr_regbank dcr_regbank_props i_props (.SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .IO_ADDR_IN(IO_ADDR_IN),
   .IO_RD_IN(IO_RD_IN), .IO_WR_IN(IO_WR_IN), .BASE_SEL_IN(BASE_SEL_IN), .IO_RDATA_OUT(IO_RDATA_OUT),
   .CONV_DONE_IN(CONV_DONE_IN), .MODE_OUT(MODE_OUT), .AO_A_OUT(AO_A_OUT), .CONV_START_OUT(CONV_START_OUT),
   .IRQ_OUT(IRQ_OUT));

// ### test/dcr_host_model.sv
// host processor model issuing single-cycle I/O strobes
`timescale 1ns/1ps
module dcr_host_model (
   input wire clk_in, // bus clock
   output reg [9:0] addr_out, // I/O address
   output reg rd_out, // read strobe
   output reg wr_out, // write strobe
   output reg [7:0] wdata_out // write data
);
   // quiet bus at time zero
   initial begin
      addr_out = 10'h000;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 8'h00;
   end
   // one strobe cycle; afterwards address and data flip so no stale value passes for a held one
   task cycle(input [9:0] a, input w, input [7:0] d);
      begin
         @(posedge clk_in) #1;
         addr_out = a;
         wdata_out = d;
         rd_out = !w;
         wr_out = w;
         @(posedge clk_in) #1;
         rd_out = 1'b0;
         wr_out = 1'b0;
         addr_out = ~a;
         wdata_out = ~d;
      end
   endtask
endmodule // dcr_host_model

// ### test/dcr_regbank_tb_top.sv
// self-checking bench for the card register bank
`timescale 1ns/1ps
module dcr_regbank_tb_top;
   localparam [9:0] B = 10'h220;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg done_p = 1'b0;
   reg high_gain = 1'b0;
   reg diff = 1'b0;
   wire [15:0] dout;
   reg [5:0] base_sel = 6'h22;
   wire [9:0] addr;
   wire rd, wr, start, irq, one_sided;
   wire [7:0] wdata, rdata;
   wire [11:0] ao_a, ao_b;
   wire [3:0] gcode, chsel;
   wire [9:0] gx2;
   wire [2:0] mode;
   integer fail_count = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer i;
   reg [7:0] rd_exp [0:15] = '{8'h5a, 8'h5a, 8'h5a, 8'h00, 8'he7, 8'h09, 8'hc3, 8'ha5,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   reg [9:0] hg_x2 [0:3] = '{10'h002, 10'h014, 10'h0c8, 10'h3ff};
   always #25 clk = ~clk;
   dcr_host_model i_host (.clk_in(clk), .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
   dcr_regbank i_dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .IO_ADDR_IN(addr), .IO_RD_IN(rd), .IO_WR_IN(wr),
      .IO_WDATA_IN(wdata), .BASE_SEL_IN(base_sel), .IO_RDATA_OUT(rdata), .IO_SEL_OUT(), .TMR_SEL_OUT(),
      .TMR_RD_OUT(), .TMR_WR_OUT(), .TMR_WDATA_OUT(), .TMR_RDATA_IN(8'h5a), .CONV_DONE_IN(done_p),
      .CONV_RESULT_IN(12'h9e7), .DIFF_MODE_IN(diff), .DIN_IN(16'ha5c3), .HIGH_GAIN_IN(high_gain),
      .AO_A_OUT(ao_a), .AO_B_OUT(ao_b), .GAIN_CODE_OUT(gcode), .GAIN_FACTOR_X2_OUT(gx2),
      .GAIN_ONE_SIDED_OUT(one_sided), .CHAN_SEL_OUT(chsel), .MODE_OUT(mode), .DOUT_OUT(dout),
      .CONV_START_OUT(start), .IRQ_OUT(irq));
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // write, then one spare edge so the new value has landed
   task wr_reg(input [9:0] a, input [7:0] d);
      begin
         i_host.cycle(a, 1'b1, d);
         @(posedge clk) #1;
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // hang guard: whole run is well under this many cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         fail_count = fail_count + 1;
         end_sim;
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      chk("ao_a", ao_a, 16'h0000);
      chk("irq", irq, 16'h0000);
      chk("gain x2", gx2, 16'h0002);
      $display("test done: reset");
      for (i = 0; i < 16; i = i + 1) begin
         i_host.cycle(B + i[9:0], 1'b0, 8'h00);
         chk("read row", rdata, rd_exp[i]);
      end
      $display("test done: read table");
      wr_reg(B + 10'h004, 8'h34);
      chk("ao_a held", ao_a, 16'h0000);
      wr_reg(B + 10'h005, 8'hf2);
      chk("ao_a", ao_a, 16'h0234);
      wr_reg(B + 10'h005, 8'h07);
      chk("ao_a stale", ao_a, 16'h0734);
      wr_reg(B + 10'h006, 8'h11);
      wr_reg(B + 10'h007, 8'h0c);
      chk("ao_b", ao_b, 16'h0c11);
      $display("test done: outputs");
      for (i = 0; i < 8; i = i + 1) begin
         wr_reg(B + 10'h009, 8'hf0 | i[7:0]);
         chk("gain code", gcode, i[15:0]);
         chk("gain x2", gx2, 16'h0002 << i[1:0]);
         chk("one sided", one_sided, i[2]);
      end
      wr_reg(B + 10'h009, 8'h08);
      chk("gain half", gx2, 16'h0001);
      @(posedge clk) #1 high_gain = 1'b1;
      // host side waits before trusting the new gain
      repeat (5) @(posedge clk);
      for (i = 0; i < 4; i = i + 1) begin
         wr_reg(B + 10'h009, i[7:0]);
         chk("gain x2 high", gx2, hg_x2[i]);
      end
      wr_reg(B + 10'h00a, 8'hff);
      chk("channel", chsel, 16'h000f);
      @(posedge clk) #1 diff = 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("channel diff", chsel, 16'h0007);
      wr_reg(B + 10'h00d, 8'h3c);
      wr_reg(B + 10'h00e, 8'h96);
      chk("dout", dout, 16'h963c);
      $display("test done: gain and channel");
      wr_reg(B + 10'h00b, 8'h06);
      chk("mode", mode, 16'h0006);
      for (i = 0; i < 2; i = i + 1) begin
         wr_reg(B + 10'h00c, 8'h5b);
         i_host.cycle(B + 10'h005, 1'b0, 8'h00);
         chk("busy set", rdata, 16'h0019);
         @(posedge clk) #1 done_p = 1'b1;
         @(posedge clk) #1 done_p = 1'b0;
         i_host.cycle(B + 10'h005, 1'b0, 8'h00);
         chk("busy clear", rdata, 16'h0009);
         chk("irq set", irq, 16'h0001);
         wr_reg(B + 10'h008, 8'ha7);
         chk("irq clear", irq, 16'h0000);
      end
      $display("test done: conversion");
      wr_reg(10'h325, 8'h0f);
      i_host.cycle(10'h325, 1'b0, 8'h00);
      chk("miss ao_a", ao_a, 16'h0734);
      chk("miss read", rdata, 16'h0009);
      $display("test done: address miss");
      end_sim;
   end
endmodule // dcr_regbank_tb_top
